// File: capture_pkg.sv
package capture_pkg;
  // Register offsets (word addresses on the plain port)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_DIV = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_MASK = 4'h3;
  localparam logic [3:0] ADDR_DATA = 4'h4;
  localparam logic [3:0] ADDR_COUNT = 4'h5;
  // Control fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_FRAMED = 1;
  localparam int CTRL_LSB_FIRST = 2;
  localparam int CTRL_AUTO = 3;
  localparam int CTRL_LEN_LO = 8;
  localparam int CTRL_LEN_W = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0e0a;
  // Status bits
  localparam int ST_RX = 0;
  localparam int ST_DUMMY = 1;
  localparam int ST_OVR = 2;
  localparam int ST_W = 3;
  // Word lengths
  localparam logic [5:0] LEN_FIRST = 6'h0f;
  localparam logic [5:0] LEN_NORMAL = 6'h10;
  localparam logic [5:0] LEN_MIN = 6'h03;
  localparam logic [5:0] LEN_MAX = 6'h20;
  localparam logic [1:0] DUMMY_WORDS = 2'h2;
  // Frame period, in core cycles, and convert-start pulse width
  localparam logic [15:0] DIV_RESET = 16'h0028;
  localparam logic [15:0] DIV_MIN = 16'h0004;
  localparam int CLK_NS = 50;
  localparam int PULSE_NS = 50;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  // Receive engine states
  typedef enum logic [1:0] {
    RX_OFF = 2'b00,
    RX_HUNT = 2'b01,
    RX_SHIFT = 2'b10
  } rx_state_e;
endpackage : capture_pkg

// File: rx_link_if.sv
`timescale 1ns/1ns
interface rx_link_if;
  logic bit_rise;
  logic frame_act;
  logic data_bit;
  modport source (output bit_rise, output frame_act, output data_bit);
  modport sink (input bit_rise, input frame_act, input data_bit);
endinterface : rx_link_if

// File: link_sampler.sv
`timescale 1ns/1ns
module link_sampler (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Converter pins
  input wire logic rx_bit_clock_in,
  input wire logic rx_frame_pulse_in_n,
  input wire logic converter_serial_out,
  // Sampled events toward the receiver
  rx_link_if.source link
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic clk_prev;
  } samp_s;
  samp_s r_q;
  samp_s r_d;

  always_comb
  begin
    r_d = r_q;
    r_d.s1 = {rx_bit_clock_in, rx_frame_pulse_in_n, converter_serial_out};
    r_d.s2 = r_q.s1;
    r_d.clk_prev = r_q.s2[2];
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      r_q <= '{s1: 3'h2, s2: 3'h2, clk_prev: 1'b0};
    else
      r_q <= r_d;
  end

  // Data and frame are read on the rising edge of the link clock
  assign link.bit_rise = r_q.s2[2] & ~r_q.clk_prev;
  assign link.frame_act = ~r_q.s2[1];
  assign link.data_bit = r_q.s2[0];
endmodule : link_sampler

// File: adc_serial_capture_port.sv
`timescale 1ns/1ns
// Summary of operation
// - Transmit frame pulse is active low, early, and drives convert-start.
// - Frame pulse recurs periodically with no data written.
// - Receive bit clock and frame sync are external inputs.
// - Receive frame sync is active low and coincides with first bit.
// - Data is sampled on rising edges of the external bit clock.
// - After enable, words are 15 bits long.
// - After the first word, length becomes 16 bits on the fly.
// - First two words after enable are discarded as dummies.
// - Framed or unframed reception is selectable.
// - Word length is selectable from 3 to 32 bits.
// - LSB-first or MSB-first shifting is selectable.
// - Bit rate up to half the core clock rate is supported.
module adc_serial_capture_port (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Converter link
  output logic convert_start_n,
  input wire logic rx_bit_clock_in,
  input wire logic rx_frame_pulse_in_n,
  input wire logic converter_serial_out,
  // Sample stream and interrupt
  output logic [31:0] sample_data,
  output logic sample_valid,
  output logic irq
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] div;
    logic [15:0] frame_cnt;
    logic [7:0] pulse_cnt;
    logic tx_pulse;
    capture_pkg::rx_state_e st;
    logic [5:0] len;
    logic [5:0] bits;
    logic [31:0] shreg;
    logic [1:0] words;
    logic [31:0] data;
    logic valid;
    logic [15:0] count;
    logic [capture_pkg::ST_W-1:0] status;
    logic [capture_pkg::ST_W-1:0] mask;
    logic [31:0] rdata;
  } core_s;
  core_s r_q;
  core_s r_d;

  rx_link_if link ();

  link_sampler u_samp (
    .mclk(mclk),
    .rst_n(rst_n),
    .rx_bit_clock_in(rx_bit_clock_in),
    .rx_frame_pulse_in_n(rx_frame_pulse_in_n),
    .converter_serial_out(converter_serial_out),
    .link(link)
  );

  // Clamp a configured length into the supported span
  function automatic logic [5:0] clamp_len(input logic [4:0] f);
    logic [5:0] v;
    v = {1'b0, f} + 6'h01;
    if (v < capture_pkg::LEN_MIN)
      clamp_len = capture_pkg::LEN_MIN;
    else
      clamp_len = v;
  endfunction : clamp_len

  // Align an assembled word so its first bit lands at the correct end
  function automatic logic [31:0] align_word(input logic [31:0] sh, input logic [5:0] n,
                                             input logic lsb);
    logic [31:0] o;
    o = 32'h0;
    for (int i = 0; i < 32; i++)
    begin
      if (i < int'(n))
      begin
        if (lsb)
          o[i] = sh[32 - int'(n) + i];
        else
          o[i] = sh[i];
      end
    end
    align_word = o;
  endfunction : align_word

  logic en;
  logic framed;
  logic lsb;
  logic [capture_pkg::ST_W-1:0] ev;
  logic [31:0] word;
  logic [31:0] shifted;
  logic last_bit;

  assign en = r_q.ctrl[capture_pkg::CTRL_EN];
  assign framed = r_q.ctrl[capture_pkg::CTRL_FRAMED];
  assign lsb = r_q.ctrl[capture_pkg::CTRL_LSB_FIRST];

  always_comb
  begin
    r_d = r_q;
    ev = '0;
    r_d.valid = 1'b0;
    r_d.rdata = 32'h0;
    // LSB-first shifts in at the top, MSB-first at the bottom
    if (lsb)
      shifted = {link.data_bit, r_q.shreg[31:1]};
    else
      shifted = {r_q.shreg[30:0], link.data_bit};
    word = align_word(shifted, r_q.len, lsb);
    last_bit = (r_q.bits + 6'h01) == r_q.len;

    // Periodic convert-start generator, free of data writes
    if (!en)
    begin
      r_d.frame_cnt = 16'h0;
      r_d.tx_pulse = 1'b0;
      r_d.pulse_cnt = 8'h0;
    end
    else if (r_q.frame_cnt == 16'h0)
    begin
      r_d.frame_cnt = r_q.div - 16'h1;
      r_d.tx_pulse = 1'b1;
      r_d.pulse_cnt = 8'(capture_pkg::PULSE_CYC);
    end
    else
    begin
      r_d.frame_cnt = r_q.frame_cnt - 16'h1;
      if (r_q.pulse_cnt > 8'h1)
        r_d.pulse_cnt = r_q.pulse_cnt - 8'h1;
      else
      begin
        r_d.pulse_cnt = 8'h0;
        r_d.tx_pulse = 1'b0;
      end
    end

    // Receive engine; one bit per sampled rising edge, up to half core rate
    case (r_q.st)
      capture_pkg::RX_OFF:
      begin
        if (en)
        begin
          r_d.st = capture_pkg::RX_HUNT;
          r_d.len = capture_pkg::LEN_FIRST;
          r_d.words = 2'h0;
          r_d.bits = 6'h0;
        end
      end
      capture_pkg::RX_HUNT:
      begin
        // Late frame: the bit under the frame is the first data bit
        if (link.bit_rise && link.frame_act)
        begin
          r_d.shreg = shifted;
          r_d.bits = 6'h1;
          r_d.st = capture_pkg::RX_SHIFT;
        end
      end
      capture_pkg::RX_SHIFT:
      begin
        if (link.bit_rise && framed && link.frame_act && (r_q.bits != 6'h0))
        begin
          // An early frame in framed mode drops the partial word and restarts
          r_d.shreg = shifted;
          r_d.bits = 6'h1;
        end
        else if (link.bit_rise)
        begin
          r_d.shreg = shifted;
          r_d.bits = r_q.bits + 6'h01;
          if (last_bit)
          begin
            r_d.bits = 6'h0;
            // Framed mode waits for a new frame; unframed runs on
            r_d.st = framed ? capture_pkg::RX_HUNT : capture_pkg::RX_SHIFT;
            if (r_q.ctrl[capture_pkg::CTRL_AUTO])
              r_d.len = capture_pkg::LEN_NORMAL;
            else
              r_d.len = clamp_len(
                r_q.ctrl[capture_pkg::CTRL_LEN_LO +: capture_pkg::CTRL_LEN_W]);
            if (r_q.words < capture_pkg::DUMMY_WORDS)
            begin
              r_d.words = r_q.words + 2'h1;
              ev[capture_pkg::ST_DUMMY] = 1'b1;
            end
            else
            begin
              r_d.data = word;
              r_d.valid = 1'b1;
              r_d.count = r_q.count + 16'h1;
              ev[capture_pkg::ST_RX] = 1'b1;
              if (r_q.status[capture_pkg::ST_RX])
                ev[capture_pkg::ST_OVR] = 1'b1;
            end
          end
        end
      end
      default:
        r_d.st = capture_pkg::RX_OFF;
    endcase
    if (!en)
      r_d.st = capture_pkg::RX_OFF;

    // Register writes; write-one clears, a new event wins over the clear
    if (reg_wr)
    begin
      case (reg_addr)
        capture_pkg::ADDR_CTRL:
        begin
          r_d.ctrl = reg_wdata;
        end
        capture_pkg::ADDR_DIV:
        begin
          r_d.div = (reg_wdata[15:0] < capture_pkg::DIV_MIN) ? capture_pkg::DIV_MIN
                    : reg_wdata[15:0];
        end
        capture_pkg::ADDR_STATUS:
        begin
          r_d.status = r_q.status & ~reg_wdata[capture_pkg::ST_W-1:0];
        end
        capture_pkg::ADDR_MASK:
        begin
          r_d.mask = reg_wdata[capture_pkg::ST_W-1:0];
        end
        capture_pkg::ADDR_COUNT:
        begin
          r_d.count = 16'h0;
        end
        default:
        begin
        end
      endcase
    end
    r_d.status = r_d.status | ev;

    if (reg_rd)
    begin
      case (reg_addr)
        capture_pkg::ADDR_CTRL:
        begin
          r_d.rdata = r_q.ctrl;
        end
        capture_pkg::ADDR_DIV:
        begin
          r_d.rdata = {16'h0, r_q.div};
        end
        capture_pkg::ADDR_STATUS:
        begin
          r_d.rdata = {29'h0, r_q.status};
        end
        capture_pkg::ADDR_MASK:
        begin
          r_d.rdata = {29'h0, r_q.mask};
        end
        capture_pkg::ADDR_DATA:
        begin
          r_d.rdata = r_q.data;
        end
        capture_pkg::ADDR_COUNT:
        begin
          r_d.rdata = {8'h0, 2'h0, r_q.len, r_q.count};
        end
        default:
        begin
          r_d.rdata = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_q <= '0;
      r_q.ctrl <= capture_pkg::CTRL_RESET;
      r_q.div <= capture_pkg::DIV_RESET;
      r_q.len <= capture_pkg::LEN_FIRST;
    end
    else
      r_q <= r_d;
  end

  assign convert_start_n = ~r_q.tx_pulse;
  assign sample_data = r_q.data;
  assign sample_valid = r_q.valid;
  assign reg_rdata = r_q.rdata;
  assign irq = |(r_q.status & r_q.mask);
endmodule : adc_serial_capture_port

// File: capture_props.sv
`timescale 1ns/1ns
module capture_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Converter link
  input wire logic convert_start_n,
  input wire logic rx_bit_clock_in,
  input wire logic rx_frame_pulse_in_n,
  input wire logic converter_serial_out,
  // Sample stream
  input wire logic [31:0] sample_data,
  input wire logic sample_valid,
  input wire logic irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic en_q;
  logic [31:0] mask_q;
  logic [3:0] age_q;
  logic [1:0] falls_q;
  logic bclk_q;
  logic cs_q;
  // Track enable, mask, bit clock age and starts since enable
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_q <= 1'b0;
      mask_q <= 32'h0;
      age_q <= 4'hf;
      falls_q <= 2'h0;
      bclk_q <= 1'b0;
      cs_q <= 1'b1;
    end
    else
    begin
      bclk_q <= rx_bit_clock_in;
      cs_q <= convert_start_n;
      if (reg_wr && reg_addr == capture_pkg::ADDR_CTRL)
        en_q <= reg_wdata[capture_pkg::CTRL_EN];
      if (reg_wr && reg_addr == capture_pkg::ADDR_MASK)
        mask_q <= reg_wdata;
      if (rx_bit_clock_in && !bclk_q)
        age_q <= 4'h0;
      else if (age_q != 4'hf)
        age_q <= age_q + 4'h1;
      if (!en_q)
        falls_q <= 2'h0;
      else if (cs_q && !convert_start_n && falls_q != 2'h3)
        falls_q <= falls_q + 2'h1;
    end
  end
  sequence gap_after_pulse;
    convert_start_n [*3];
  endsequence
  chk_pulse_gap: assert property ($fell(convert_start_n) |=> gap_after_pulse)
    else $error("convert start pulse too long or too close");
  chk_idle_off: assert property (!en_q && !$past(en_q) |-> convert_start_n)
    else $error("convert start while disabled");
  chk_valid_once: assert property (sample_valid |=> !sample_valid [*8])
    else $error("sample strobe not single");
  chk_data_hold: assert property (!sample_valid |-> $stable(sample_data))
    else $error("sample data moved without strobe");
  chk_rise_age: assert property (sample_valid |-> age_q inside {[1:6]})
    else $error("sample not tied to bit clock rise");
  chk_two_dummies: assert property (sample_valid |-> falls_q == 2'h3)
    else $error("sample before two dummy words");
  chk_irq_masked: assert property (irq |-> (|mask_q) || (|$past(mask_q)))
    else $error("interrupt with all masked");
  chk_valid_irq: assert property (sample_valid && mask_q[0] |-> ##[0:2] irq)
    else $error("no interrupt after sample");
endmodule : capture_props

// File: adc_converter_model.sv
`timescale 1ns/1ns
module adc_converter_model (
  // Convert control and next result
  input wire logic convert_start_n,
  input wire logic [15:0] word,
  // Serial link
  output logic rx_bit_clock_in,
  output logic rx_frame_pulse_in_n,
  output logic converter_serial_out
);
  logic [15:0] res;
  initial
  begin
    rx_bit_clock_in = 1'b0;
    rx_frame_pulse_in_n = 1'b1;
    converter_serial_out = 1'b0;
  end
  // Hold and convert, then shift the result with a gated clock
  always @(negedge convert_start_n)
  begin
    res = word;
    // Conversion time, kept off the core clock edges
    #1010;
    for (int i = 15; i >= 0; i--)
    begin
      rx_bit_clock_in = 1'b0;
      converter_serial_out = res[i];
      rx_frame_pulse_in_n = (i == 15) ? 1'b0 : 1'b1;
      #200;
      rx_bit_clock_in = 1'b1;
      #200;
    end
    rx_bit_clock_in = 1'b0;
    rx_frame_pulse_in_n = 1'b1;
    converter_serial_out = ~res[0];
  end
endmodule : adc_converter_model

// File: adc_serial_capture_port_tb_top.sv
`timescale 1ns/1ns
module adc_serial_capture_port_tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, sample_data, d;
  logic convert_start_n, rx_bit_clock_in, rx_frame_pulse_in_n;
  logic converter_serial_out, sample_valid, irq;
  logic [15:0] word = 16'h0;
  int mismatches = 0;
  int samples_checked = 0;
  int falls = 0;
  int cycles = 0;
  time t_last = 0;
  time period = 0;
  always #25 mclk = ~mclk;
  always @(negedge convert_start_n)
  begin
    falls++;
    period = $time - t_last;
    t_last = $time;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      summarize();
    end
  end
  adc_serial_capture_port u_adc_serial_capture_port (.mclk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .convert_start_n, .rx_bit_clock_in, .rx_frame_pulse_in_n,
    .converter_serial_out, .sample_data, .sample_valid, .irq);
  adc_converter_model u_adc_converter_model (.convert_start_n, .word, .rx_bit_clock_in,
    .rx_frame_pulse_in_n, .converter_serial_out);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic wait_valid;
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    while (sample_valid !== 1'b1 && n < 2000);
    check(32'(sample_valid), 32'h1);
  endtask : wait_valid
  task automatic restart(input logic [31:0] v);
    wr(capture_pkg::ADDR_CTRL, 32'h0);
    repeat (40) @(posedge mclk);
    falls = 0;
    wr(capture_pkg::ADDR_CTRL, v);
  endtask : restart
  task automatic summarize;
    $display("Compared %0d values, %0d mismatches", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    word = 16'hc3a5;
    rd(capture_pkg::ADDR_CTRL);
    check(d, capture_pkg::CTRL_RESET);
    wr(capture_pkg::ADDR_DIV, 32'h0000_0001);
    rd(capture_pkg::ADDR_DIV);
    check(d, 32'(capture_pkg::DIV_MIN));
    wr(capture_pkg::ADDR_DIV, 32'h0000_00c8);
    #1 check(32'(convert_start_n), 32'h1);
    wr(capture_pkg::ADDR_MASK, 32'h0000_0001);
    wr(capture_pkg::ADDR_CTRL, 32'h0000_0e0b);
    wait_valid();
    check(32'(falls), 32'h3);
    check(sample_data, 32'h0000_c3a5);
    rd(capture_pkg::ADDR_STATUS);
    check(d, 32'h3);
    check(32'(irq), 32'h1);
    rd(capture_pkg::ADDR_DATA);
    check(d, 32'h0000_c3a5);
    wr(capture_pkg::ADDR_STATUS, 32'h1);
    rd(capture_pkg::ADDR_STATUS);
    check(d, 32'h2);
    check(32'(irq), 32'h0);
    rd(capture_pkg::ADDR_COUNT);
    check(d, 32'h0010_0001);
    rd(4'hf);
    check(d, 32'h0);
    word = 16'h0001;
    wait_valid();
    check(sample_data, 32'h0000_0001);
    check(32'(period), 32'h0000_2710);
    restart(32'h0000_0e0f);
    wait_valid();
    check(sample_data, 32'h0000_8000);
    check(32'(falls), 32'h3);
    word = 16'hc3a5;
    restart(32'h0000_0b03);
    wait_valid();
    check(sample_data, 32'h0000_0c3a);
    rd(capture_pkg::ADDR_COUNT);
    check(32'(d[21:16]), 32'h0000_000c);
    word = 16'hffff;
    restart(32'h0000_0e09);
    wait_valid();
    check(sample_data, 32'h0000_ffff);
    check(32'(falls), 32'h3);
    summarize();
  end
endmodule : adc_serial_capture_port_tb_top
bind adc_serial_capture_port capture_props u_capture_props (.mclk, .rst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .convert_start_n, .rx_bit_clock_in,
  .rx_frame_pulse_in_n, .converter_serial_out, .sample_data, .sample_valid, .irq);
